/* src/csf_pkg.sv */
// csf_pkg: shared constants and carrier types for the cpu status flag block
// assumes a 32-bit apb register bus and a 16-bit execution datapath on one clock
package csf_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the apb bus
	localparam int unsigned    CSF_ADDR_W      = 8;
	localparam logic [7:0]     CSF_OFF_STATUS  = 8'h00;
	localparam logic [7:0]     CSF_OFF_EVENT   = 8'h04;
	localparam logic [7:0]     CSF_OFF_MASK    = 8'h08;
	localparam logic [7:0]     CSF_OFF_CONTROL = 8'h0c;

	////////////////////////////////////////////////////////////////////////////
	// cpu_status_word field positions
	localparam int unsigned    CSF_BIT_OVF_A   = 15;
	localparam int unsigned    CSF_BIT_OVF_B   = 14;
	localparam int unsigned    CSF_BIT_CLMP_A  = 13;
	localparam int unsigned    CSF_BIT_CLMP_B  = 12;
	localparam int unsigned    CSF_BIT_OVF_OR  = 11;
	localparam int unsigned    CSF_BIT_CLMP_OR = 10;
	localparam int unsigned    CSF_BIT_LOOP    = 9;
	localparam int unsigned    CSF_BIT_HCARRY  = 8;
	localparam int unsigned    CSF_BIT_PRIO_HI = 7;
	localparam int unsigned    CSF_BIT_PRIO_LO = 5;
	localparam int unsigned    CSF_BIT_RPT     = 4;
	localparam int unsigned    CSF_BIT_N       = 3;
	localparam int unsigned    CSF_BIT_WRAP    = 2;
	localparam int unsigned    CSF_BIT_Z       = 1;
	localparam int unsigned    CSF_BIT_C       = 0;
	localparam logic [15:0]    CSF_STATUS_RST  = 16'h0000;
	localparam logic [2:0]     CSF_PRIO_RST    = 3'h0;
	localparam logic [2:0]     CSF_PRIO_MAX    = 3'h7;

	////////////////////////////////////////////////////////////////////////////
	// control register: priority top bit and nesting disable
	localparam int unsigned    CSF_CTL_TOP     = 0;
	localparam int unsigned    CSF_CTL_NSTD    = 1;
	localparam int unsigned    CSF_CTL_W       = 2;
	localparam logic [1:0]     CSF_CTL_RST     = 2'h0;

	////////////////////////////////////////////////////////////////////////////
	// event status and mask layout
	localparam int unsigned    CSF_EVT_OVF_A   = 0;
	localparam int unsigned    CSF_EVT_OVF_B   = 1;
	localparam int unsigned    CSF_EVT_SAT_A   = 2;
	localparam int unsigned    CSF_EVT_SAT_B   = 3;
	localparam int unsigned    CSF_EVT_WRAP    = 4;
	localparam int unsigned    CSF_EVT_W       = 5;
	localparam logic [4:0]     CSF_EVT_RST     = 5'h00;
	localparam logic [4:0]     CSF_MASK_RST    = 5'h00;

	////////////////////////////////////////////////////////////////////////////
	// alu sizes: half carry taps bit 3 for bytes and bit 7 for words
	localparam int unsigned    CSF_DATA_W      = 16;
	localparam int unsigned    CSF_BYTE_W      = 8;
	localparam int unsigned    CSF_HC_BYTE     = 4;
	localparam int unsigned    CSF_HC_WORD     = 8;

	typedef struct packed {
		logic        valid;
		logic        sub;
		logic        byte_mode;
		logic        carry_in;
		logic [15:0] opa;
		logic [15:0] opb;
	} csf_alu_op_t;

	typedef struct packed {
		logic n;
		logic wrap;
		logic z;
		logic c;
		logic hc;
	} csf_alu_flags_t;

	typedef struct packed {
		logic valid;
		logic ovf_a;
		logic ovf_b;
		logic sat_a;
		logic sat_b;
	} csf_dsp_evt_t;

endpackage

/* src/csf_alu_flags.sv */
// csf_alu_flags: combinational flag generation for one add or subtract
// assumes operands valid in the same cycle; subtract means a + ~b + carry_in
`timescale 1ns/100ps
module csf_alu_flags (
	input  csf_pkg::csf_alu_op_t    op_in,
	output csf_pkg::csf_alu_flags_t flags_out
);
	import csf_pkg::*;

	logic [CSF_DATA_W-1:0] b_eff;
	logic [CSF_DATA_W:0]   sum_full;
	logic [CSF_HC_BYTE:0]  nib_sum;
	logic [CSF_HC_WORD:0]  byte_sum;
	logic                  msb_a;
	logic                  msb_b;
	logic                  msb_r;

	always_comb begin
		b_eff     = op_in.sub ? ~op_in.opb : op_in.opb;
		sum_full  = {1'b0, op_in.opa} + {1'b0, b_eff} + {{CSF_DATA_W{1'b0}}, op_in.carry_in};
		nib_sum   = {1'b0, op_in.opa[CSF_HC_BYTE-1:0]} + {1'b0, b_eff[CSF_HC_BYTE-1:0]}
			+ {{CSF_HC_BYTE{1'b0}}, op_in.carry_in};
		byte_sum  = {1'b0, op_in.opa[CSF_HC_WORD-1:0]} + {1'b0, b_eff[CSF_HC_WORD-1:0]}
			+ {{CSF_HC_WORD{1'b0}}, op_in.carry_in};
		if (op_in.byte_mode) begin
			msb_a        = op_in.opa[CSF_BYTE_W-1];
			msb_b        = b_eff[CSF_BYTE_W-1];
			msb_r        = sum_full[CSF_BYTE_W-1];
			flags_out.c  = byte_sum[CSF_HC_WORD];
			flags_out.z  = (sum_full[CSF_BYTE_W-1:0] == 8'h00);
			flags_out.hc = nib_sum[CSF_HC_BYTE];
		end else begin
			msb_a        = op_in.opa[CSF_DATA_W-1];
			msb_b        = b_eff[CSF_DATA_W-1];
			msb_r        = sum_full[CSF_DATA_W-1];
			flags_out.c  = sum_full[CSF_DATA_W];
			flags_out.z  = (sum_full[CSF_DATA_W-1:0] == 16'h0000);
			flags_out.hc = byte_sum[CSF_HC_WORD];
		end
		flags_out.n    = msb_r;
		// like-signed inputs whose sum flips sign
		flags_out.wrap = (msb_a == msb_b) && (msb_r != msb_a);
	end

endmodule

/* src/csf_status_flags.sv */
// csf_status_flags: cpu status word with dsp, loop, priority and alu flags
// assumes datapath strobes on REF_CLK_IN and an apb master for software access
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module csf_status_flags (
	input  wire logic                   REF_CLK_IN,
	input  wire logic                   SYS_RST_IN,
	input  wire logic                   PSEL_IN,
	input  wire logic                   PENABLE_IN,
	input  wire logic                   PWRITE_IN,
	input  wire logic [7:0]             PADDR_IN,
	input  wire logic [31:0]            PWDATA_IN,
	input  wire logic [3:0]             PSTRB_IN,
	output logic      [31:0]            PRDATA_OUT,
	output logic                        PREADY_OUT,
	output logic                        PSLVERR_OUT,
	input  csf_pkg::csf_alu_op_t        ALU_OP_IN,
	input  csf_pkg::csf_dsp_evt_t       DSP_EVT_IN,
	input  wire logic                   REPEAT_ACTIVE_IN,
	input  wire logic                   DO_LOOP_ACTIVE_IN,
	output logic      [15:0]            STATUS_WORD_OUT,
	output logic      [3:0]             PRIORITY_LEVEL_OUT,
	output logic                        USER_IRQ_BLOCKED_OUT,
	output logic                        IRQ_OUT
);
	import csf_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// alu flag generation

	csf_alu_flags_t alu_flags;

	csf_alu_flags u_alu_flags (
		.op_in     (ALU_OP_IN),
		.flags_out (alu_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic        setup_phase;
	logic        access_wr;
	logic        addr_ok;
	logic        wr_status;
	logic        wr_event;
	logic        wr_mask;
	logic        wr_ctrl;
	logic        lane0;
	logic        lane1;
	logic [15:0] wdata16;

	always_comb begin
		setup_phase = PSEL_IN && !PENABLE_IN;
		access_wr   = PSEL_IN && PENABLE_IN && PWRITE_IN;
		addr_ok     = (PADDR_IN == CSF_OFF_STATUS) || (PADDR_IN == CSF_OFF_EVENT)
			|| (PADDR_IN == CSF_OFF_MASK) || (PADDR_IN == CSF_OFF_CONTROL);
		wr_status   = access_wr && (PADDR_IN == CSF_OFF_STATUS);
		wr_event    = access_wr && (PADDR_IN == CSF_OFF_EVENT) && PSTRB_IN[0];
		wr_mask     = access_wr && (PADDR_IN == CSF_OFF_MASK) && PSTRB_IN[0];
		wr_ctrl     = access_wr && (PADDR_IN == CSF_OFF_CONTROL) && PSTRB_IN[0];
		lane0       = wr_status && PSTRB_IN[0];
		lane1       = wr_status && PSTRB_IN[1];
		wdata16     = PWDATA_IN[15:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// dsp flags: overflow and sticky clamp

	logic ovf_a_reg;
	logic ovf_a_next;
	logic ovf_b_reg;
	logic ovf_b_next;
	logic clmp_a_reg;
	logic clmp_a_next;
	logic clmp_b_reg;
	logic clmp_b_next;

	always_comb begin
		ovf_a_next  = ovf_a_reg;
		ovf_b_next  = ovf_b_reg;
		clmp_a_next = clmp_a_reg;
		clmp_b_next = clmp_b_reg;
		if (lane1) begin
			ovf_a_next  = wdata16[CSF_BIT_OVF_A];
			ovf_b_next  = wdata16[CSF_BIT_OVF_B];
			// zero in the combined bit clears both sticky bits
			clmp_a_next = wdata16[CSF_BIT_CLMP_A] && wdata16[CSF_BIT_CLMP_OR];
			clmp_b_next = wdata16[CSF_BIT_CLMP_B] && wdata16[CSF_BIT_CLMP_OR];
		end
		if (DSP_EVT_IN.valid) begin
			ovf_a_next = DSP_EVT_IN.ovf_a;
			ovf_b_next = DSP_EVT_IN.ovf_b;
			// saturation sets win over a software clear
			if (DSP_EVT_IN.sat_a) begin
				clmp_a_next = 1'b1;
			end
			if (DSP_EVT_IN.sat_b) begin
				clmp_b_next = 1'b1;
			end
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			ovf_a_reg  <= CSF_STATUS_RST[CSF_BIT_OVF_A];
			ovf_b_reg  <= CSF_STATUS_RST[CSF_BIT_OVF_B];
			clmp_a_reg <= CSF_STATUS_RST[CSF_BIT_CLMP_A];
			clmp_b_reg <= CSF_STATUS_RST[CSF_BIT_CLMP_B];
		end else begin
			ovf_a_reg  <= ovf_a_next;
			ovf_b_reg  <= ovf_b_next;
			clmp_a_reg <= clmp_a_next;
			clmp_b_reg <= clmp_b_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// alu result flags and loop indicators

	logic       n_reg;
	logic       n_next;
	logic       wrap_reg;
	logic       wrap_next;
	logic       z_reg;
	logic       z_next;
	logic       c_reg;
	logic       c_next;
	logic       hc_reg;
	logic       hc_next;
	logic       rpt_reg;
	logic       loop_reg;

	always_comb begin
		n_next    = n_reg;
		wrap_next = wrap_reg;
		z_next    = z_reg;
		c_next    = c_reg;
		hc_next   = hc_reg;
		if (lane0) begin
			n_next    = wdata16[CSF_BIT_N];
			wrap_next = wdata16[CSF_BIT_WRAP];
			z_next    = wdata16[CSF_BIT_Z];
			c_next    = wdata16[CSF_BIT_C];
		end
		if (lane1) begin
			hc_next = wdata16[CSF_BIT_HCARRY];
		end
		// an alu update in the same cycle overrides software
		if (ALU_OP_IN.valid) begin
			n_next    = alu_flags.n;
			wrap_next = alu_flags.wrap;
			z_next    = alu_flags.z;
			c_next    = alu_flags.c;
			hc_next   = alu_flags.hc;
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			n_reg    <= CSF_STATUS_RST[CSF_BIT_N];
			wrap_reg <= CSF_STATUS_RST[CSF_BIT_WRAP];
			z_reg    <= CSF_STATUS_RST[CSF_BIT_Z];
			c_reg    <= CSF_STATUS_RST[CSF_BIT_C];
			hc_reg   <= CSF_STATUS_RST[CSF_BIT_HCARRY];
			rpt_reg  <= CSF_STATUS_RST[CSF_BIT_RPT];
			loop_reg <= CSF_STATUS_RST[CSF_BIT_LOOP];
		end else begin
			n_reg    <= n_next;
			wrap_reg <= wrap_next;
			z_reg    <= z_next;
			c_reg    <= c_next;
			hc_reg   <= hc_next;
			rpt_reg  <= REPEAT_ACTIVE_IN;
			loop_reg <= DO_LOOP_ACTIVE_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// priority field and control

	logic [2:0]           prio_reg;
	logic [2:0]           prio_next;
	logic [CSF_CTL_W-1:0] ctrl_reg;
	logic [CSF_CTL_W-1:0] ctrl_next;

	always_comb begin
		prio_next = prio_reg;
		ctrl_next = ctrl_reg;
		if (lane0 && !ctrl_reg[CSF_CTL_NSTD]) begin
			prio_next = wdata16[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO];
		end
		if (wr_ctrl) begin
			ctrl_next = PWDATA_IN[CSF_CTL_W-1:0];
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			prio_reg <= CSF_PRIO_RST;
			ctrl_reg <= CSF_CTL_RST;
		end else begin
			prio_reg <= prio_next;
			ctrl_reg <= ctrl_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// events, mask and interrupt

	logic [CSF_EVT_W-1:0] evt_reg;
	logic [CSF_EVT_W-1:0] evt_next;
	logic [CSF_EVT_W-1:0] evt_set;
	logic [CSF_EVT_W-1:0] evt_clr;
	logic [CSF_EVT_W-1:0] mask_reg;
	logic [CSF_EVT_W-1:0] mask_next;
	logic                 irq_reg;
	logic                 irq_next;

	always_comb begin
		evt_set                 = '0;
		evt_set[CSF_EVT_OVF_A]  = DSP_EVT_IN.valid && DSP_EVT_IN.ovf_a;
		evt_set[CSF_EVT_OVF_B]  = DSP_EVT_IN.valid && DSP_EVT_IN.ovf_b;
		evt_set[CSF_EVT_SAT_A]  = DSP_EVT_IN.valid && DSP_EVT_IN.sat_a;
		evt_set[CSF_EVT_SAT_B]  = DSP_EVT_IN.valid && DSP_EVT_IN.sat_b;
		evt_set[CSF_EVT_WRAP]   = ALU_OP_IN.valid && alu_flags.wrap;
		evt_clr                 = wr_event ? PWDATA_IN[CSF_EVT_W-1:0] : '0;
		// set wins over write-one-to-clear
		evt_next                = (evt_reg & ~evt_clr) | evt_set;
		mask_next               = wr_mask ? PWDATA_IN[CSF_EVT_W-1:0] : mask_reg;
		irq_next                = |(evt_next & mask_next);
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			evt_reg  <= CSF_EVT_RST;
			mask_reg <= CSF_MASK_RST;
			irq_reg  <= 1'b0;
		end else begin
			evt_reg  <= evt_next;
			mask_reg <= mask_next;
			irq_reg  <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status word assembly

	logic [15:0] status_word;

	always_comb begin
		status_word                              = CSF_STATUS_RST;
		status_word[CSF_BIT_OVF_A]                   = ovf_a_reg;
		status_word[CSF_BIT_OVF_B]                   = ovf_b_reg;
		status_word[CSF_BIT_CLMP_A]                  = clmp_a_reg;
		status_word[CSF_BIT_CLMP_B]                  = clmp_b_reg;
		status_word[CSF_BIT_OVF_OR]                  = ovf_a_reg || ovf_b_reg;
		status_word[CSF_BIT_CLMP_OR]                 = clmp_a_reg || clmp_b_reg;
		status_word[CSF_BIT_LOOP]                    = loop_reg;
		status_word[CSF_BIT_HCARRY]                  = hc_reg;
		status_word[CSF_BIT_PRIO_HI:CSF_BIT_PRIO_LO] = prio_reg;
		status_word[CSF_BIT_RPT]                     = rpt_reg;
		status_word[CSF_BIT_N]                       = n_reg;
		status_word[CSF_BIT_WRAP]                    = wrap_reg;
		status_word[CSF_BIT_Z]                   = z_reg;
		status_word[CSF_BIT_C]                   = c_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// apb read data and error, captured in the setup cycle

	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic        err_reg;
	logic        err_next;

	always_comb begin
		rdata_next = rdata_reg;
		err_next   = err_reg;
		if (setup_phase) begin
			err_next = !addr_ok;
			case (PADDR_IN)
				CSF_OFF_STATUS: begin
					rdata_next = {16'h0000, status_word};
				end
				CSF_OFF_EVENT: begin
					rdata_next = {{(32-CSF_EVT_W){1'b0}}, evt_reg};
				end
				CSF_OFF_MASK: begin
					rdata_next = {{(32-CSF_EVT_W){1'b0}}, mask_reg};
				end
				CSF_OFF_CONTROL: begin
					rdata_next = {{(32-CSF_CTL_W){1'b0}}, ctrl_reg};
				end
				default: begin
					rdata_next = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_IN) begin
		if (SYS_RST_IN) begin
			rdata_reg <= 32'h0000_0000;
			err_reg   <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			err_reg   <= err_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	always_comb begin
		PRDATA_OUT           = rdata_reg;
		PREADY_OUT           = 1'b1;
		PSLVERR_OUT          = PSEL_IN && PENABLE_IN && err_reg;
		STATUS_WORD_OUT      = status_word;
		PRIORITY_LEVEL_OUT   = {ctrl_reg[CSF_CTL_TOP], prio_reg};
		USER_IRQ_BLOCKED_OUT = (prio_reg == CSF_PRIO_MAX);
		IRQ_OUT              = irq_reg;
	end

endmodule

/* bench/csf_status_properties.sv */
// csf_status_checker: concurrent checks on the status flag block ports
// assumes one clock domain with a synchronous active high reset
`timescale 1ns/100ps
module csf_status_checker
	import csf_pkg::*;
(
	input  wire logic            REF_CLK_IN,
	input  wire logic            SYS_RST_IN,
	input  wire logic            PSEL_IN,
	input  wire logic            PENABLE_IN,
	input  wire logic            PWRITE_IN,
	input  csf_pkg::csf_alu_op_t  ALU_OP_IN,
	input  csf_pkg::csf_dsp_evt_t DSP_EVT_IN,
	input  wire logic            REPEAT_ACTIVE_IN,
	input  wire logic            DO_LOOP_ACTIVE_IN,
	input  wire logic [15:0]     STATUS_WORD_OUT,
	input  wire logic [3:0]      PRIORITY_LEVEL_OUT,
	input  wire logic            USER_IRQ_BLOCKED_OUT
);
	wire  [15:0] sw = STATUS_WORD_OUT;
	wire         wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	logic [15:0] opb_eff;
	logic [16:0] sum;
	logic        wrap;
	logic        wv;

	// reference word add or subtract
	always_comb begin
		opb_eff = ALU_OP_IN.sub ? ~ALU_OP_IN.opb : ALU_OP_IN.opb;
		sum = {1'b0, ALU_OP_IN.opa} + {1'b0, opb_eff} + {16'h0000, ALU_OP_IN.carry_in};
		wrap = (ALU_OP_IN.opa[15] == opb_eff[15]) && (sum[15] != ALU_OP_IN.opa[15]);
		wv = ALU_OP_IN.valid && !ALU_OP_IN.byte_mode && (ALU_OP_IN.sub || !ALU_OP_IN.carry_in);
	end

	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (SYS_RST_IN);

	////////////////////////////////////////////////////////////////////////////
	property p_acc_b; DSP_EVT_IN.valid |=> sw[14] == $past(DSP_EVT_IN.ovf_b); endproperty
	a_acc_b: assert property (p_acc_b) else $error("acc b overflow flag wrong");
	property p_clamp_set; DSP_EVT_IN.valid && DSP_EVT_IN.sat_a |=> sw[13]; endproperty
	a_clamp_set: assert property (p_clamp_set) else $error("clamp flag not set");
	property p_clamp_hold; sw[12] && !wr |=> sw[12]; endproperty
	a_clamp_hold: assert property (p_clamp_hold) else $error("clamp flag lost");
	property p_either; sw[11] == (sw[15] | sw[14]) && sw[10] == (sw[13] | sw[12]); endproperty
	a_either: assert property (p_either) else $error("combined flags wrong");
	property p_level; PRIORITY_LEVEL_OUT[2:0] == sw[7:5] && USER_IRQ_BLOCKED_OUT == (sw[7:5] == 3'h7); endproperty
	a_level: assert property (p_level) else $error("priority level wrong");
	property p_repeat; !$past(SYS_RST_IN) |-> sw[4] == $past(REPEAT_ACTIVE_IN); endproperty
	a_repeat: assert property (p_repeat) else $error("repeat flag wrong");
	property p_loop; !$past(SYS_RST_IN) |-> sw[9] == $past(DO_LOOP_ACTIVE_IN); endproperty
	a_loop: assert property (p_loop) else $error("loop flag wrong");
	property p_neg; wv |=> sw[3] == $past(sum[15]); endproperty
	a_neg: assert property (p_neg) else $error("sign flag wrong");
	property p_wrap; wv |=> sw[2] == $past(wrap); endproperty
	a_wrap: assert property (p_wrap) else $error("signed wrap flag wrong");
	property p_zero; wv |=> sw[1] == ($past(sum[15:0]) == 16'h0000); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	property p_carry; wv |=> sw[0] == $past(sum[16]); endproperty
	a_carry: assert property (p_carry) else $error("carry flag wrong");
endmodule

bind csf_status_flags csf_status_checker u_chk (
	.REF_CLK_IN(REF_CLK_IN),
	.SYS_RST_IN(SYS_RST_IN),
	.PSEL_IN(PSEL_IN),
	.PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN),
	.ALU_OP_IN(ALU_OP_IN),
	.DSP_EVT_IN(DSP_EVT_IN),
	.REPEAT_ACTIVE_IN(REPEAT_ACTIVE_IN),
	.DO_LOOP_ACTIVE_IN(DO_LOOP_ACTIVE_IN),
	.STATUS_WORD_OUT(STATUS_WORD_OUT),
	.PRIORITY_LEVEL_OUT(PRIORITY_LEVEL_OUT),
	.USER_IRQ_BLOCKED_OUT(USER_IRQ_BLOCKED_OUT)
);

/* bench/tb.sv */
// tb: self-checking bench for the cpu status flag block
// assumes the block answers apb transfers on its own and drives all flags from registers
`timescale 1ns/100ps
module tb;
	import csf_pkg::*;
`define CHK(n, e, g) if ((g) !== (e)) begin $display("ERROR %s exp %h got %h", n, e, g); failures++; end n_checks++;
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	logic          psel = 1'b0;
	logic          pen = 1'b0;
	logic          pw = 1'b0;
	logic [7:0]    pa = 8'h00;
	logic [31:0]   pwd = 32'h0000_0000;
	logic [3:0]    pst = 4'h0;
	logic [31:0]   rd;
	logic          slv;
	csf_alu_op_t   alu = '0;
	csf_dsp_evt_t  dsp = '0;
	logic          rep = 1'b0;
	logic          dol = 1'b0;
	wire  [31:0]   prd;
	wire           prdy;
	wire           perr;
	wire  [15:0]   sw;
	wire  [3:0]    lvl;
	wire           ublk;
	wire           irq;
	int            failures = 0;
	int            n_checks = 0;

	csf_status_flags DUT (
		.REF_CLK_IN(clk),
		.SYS_RST_IN(rst),
		.PSEL_IN(psel),
		.PENABLE_IN(pen),
		.PWRITE_IN(pw),
		.PADDR_IN(pa),
		.PWDATA_IN(pwd),
		.PSTRB_IN(pst),
		.PRDATA_OUT(prd),
		.PREADY_OUT(prdy),
		.PSLVERR_OUT(perr),
		.ALU_OP_IN(alu),
		.DSP_EVT_IN(dsp),
		.REPEAT_ACTIVE_IN(rep),
		.DO_LOOP_ACTIVE_IN(dol),
		.STATUS_WORD_OUT(sw),
		.PRIORITY_LEVEL_OUT(lvl),
		.USER_IRQ_BLOCKED_OUT(ublk),
		.IRQ_OUT(irq)
	);

	initial forever #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pw <= w;
		pa <= a;
		pwd <= d;
		pst <= 4'hf;
		@(posedge clk);
		pen <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		rd = prd;
		slv = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		#1;
	endtask

	task automatic alu_op(input logic s, input logic bm, input logic ci, input logic [15:0] a, input logic [15:0] b);
		@(posedge clk);
		alu <= {1'b1, s, bm, ci, a, b};
		@(posedge clk);
		alu <= '0;
		#1;
	endtask

	task automatic dsp_ev(input logic [3:0] f);
		@(posedge clk);
		dsp <= {1'b1, f};
		@(posedge clk);
		dsp <= '0;
		#1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		for (int a = 0; a < 16; a += 4) begin
			apb(1'b0, a[7:0], 32'h0);
			`CHK("reset value", 32'h0, rd)
			`CHK("mapped", 1'b0, slv)
		end
		apb(1'b1, 8'h10, 32'hffff_ffff);
		`CHK("unmapped write err", 1'b1, slv)
		apb(1'b0, 8'h10, 32'h0);
		`CHK("unmapped read", 33'h1_0000_0000, {slv, rd})
	endtask

	task automatic t_alu;
		alu_op(1'b0, 1'b0, 1'b0, 16'h7fff, 16'h0001);
		`CHK("add wrap", 5'h1c, {sw[8], sw[3:0]})
		alu_op(1'b1, 1'b0, 1'b1, 16'h0005, 16'h0005);
		`CHK("sub zero", 5'h13, {sw[8], sw[3:0]})
		alu_op(1'b0, 1'b1, 1'b0, 16'h0080, 16'h0080);
		`CHK("byte add", 5'h07, {sw[8], sw[3:0]})
		alu_op(1'b1, 1'b0, 1'b1, 16'h0000, 16'h0001);
		`CHK("sub borrow", 5'h08, {sw[8], sw[3:0]})
	endtask

	task automatic t_irq;
		apb(1'b1, CSF_OFF_MASK, 32'h10);
		alu_op(1'b0, 1'b0, 1'b0, 16'h7fff, 16'h0001);
		apb(1'b0, CSF_OFF_EVENT, 32'h0);
		`CHK("event", 32'h10, rd)
		`CHK("irq raised", 1'b1, irq)
		apb(1'b1, CSF_OFF_EVENT, 32'h10);
		repeat (2) @(posedge clk);
		#1;
		`CHK("irq cleared", 1'b0, irq)
		apb(1'b1, CSF_OFF_MASK, 32'h0);
		alu_op(1'b0, 1'b0, 1'b0, 16'h7fff, 16'h0001);
		repeat (2) @(posedge clk);
		#1;
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, CSF_OFF_EVENT, 32'h1f);
	endtask

	task automatic t_dsp;
		dsp_ev(4'b0100);
		`CHK("acc b ovf", 2'b11, {sw[14], sw[11]})
		dsp_ev(4'b0010);
		`CHK("clamp a", 4'b0011, {sw[14], sw[11], sw[13], sw[10]})
		dsp_ev(4'b0000);
		`CHK("clamp kept", 1'b1, sw[13])
		apb(1'b0, CSF_OFF_EVENT, 32'h0);
		`CHK("dsp events", 32'h6, rd)
		apb(1'b1, CSF_OFF_EVENT, 32'h1f);
		apb(1'b1, CSF_OFF_STATUS, 32'h0);
		`CHK("clamp cleared", 3'b000, {sw[13], sw[12], sw[10]})
		apb(1'b1, CSF_OFF_STATUS, 32'h1400);
		`CHK("clamp b written", 3'b011, {sw[13], sw[12], sw[10]})
		apb(1'b1, CSF_OFF_STATUS, 32'h1000);
		`CHK("combined zero clears", 1'b0, sw[12])
	endtask

	task automatic t_prio;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, CSF_OFF_STATUS, {24'h0, i[2:0], 5'h00});
			`CHK("level", {1'b0, i[2:0]}, lvl)
			`CHK("user blocked", (i == 7), ublk)
		end
		apb(1'b1, CSF_OFF_CONTROL, 32'h1);
		`CHK("upper level", 4'hf, lvl)
		apb(1'b1, CSF_OFF_CONTROL, 32'h3);
		apb(1'b1, CSF_OFF_STATUS, 32'h0);
		`CHK("field locked", 3'h7, sw[7:5])
		apb(1'b1, CSF_OFF_CONTROL, 32'h0);
		apb(1'b1, CSF_OFF_STATUS, 32'h0);
		`CHK("field free", 4'h0, lvl)
	endtask

	task automatic t_loops;
		@(posedge clk);
		rep <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("repeat on", 2'b10, {sw[4], sw[9]})
		@(posedge clk);
		rep <= 1'b0;
		dol <= 1'b1;
		@(posedge clk);
		#1;
		`CHK("loop on", 2'b01, {sw[4], sw[9]})
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_alu();
		t_irq();
		t_dsp();
		t_prio();
		t_loops();
		print_verdict();
	end

	initial begin
		#100us;
		failures++;
		print_verdict();
	end
endmodule
